// ===== design/ofs_pkg.sv
// constants and types shared by the output filter stage
package ofs_pkg;
  localparam int OFS_DW = 32;
  localparam int OFS_AW = 12;
  localparam int OFS_RW = 16;

  localparam logic [11:0] OFS_ADDR_ENABLE = 12'hf00;
  localparam logic [11:0] OFS_ADDR_TYPE = 12'hf01;
  localparam logic [11:0] OFS_ADDR_CAPACITY = 12'hf02;
  localparam logic [11:0] OFS_ADDR_PARAM = 12'hf03;
  localparam logic [11:0] OFS_ADDR_PRESET = 12'hf04;
  localparam logic [11:0] OFS_ADDR_DECIM = 12'hf06;
  localparam logic [11:0] OFS_ADDR_STORE = 12'hf07;
  localparam logic [11:0] OFS_ADDR_LEVEL = 12'hf08;

  localparam logic OFS_RST_ENABLE = 1'b1;
  localparam logic [1:0] OFS_RST_TYPE = 2'h1;
  localparam logic [15:0] OFS_RST_CAPACITY = 16'h000a;
  localparam logic [15:0] OFS_RST_PARAM = 16'h0002;
  localparam logic [15:0] OFS_RST_DECIM = 16'h0000;

  localparam logic [15:0] OFS_DECIM_MAX = 16'h0040;
  localparam logic [15:0] OFS_NUM_KINDS = 16'h0003;
  localparam int OFS_NOISE_TAPS = 3;

  // enum order gives the documented select codes 0, 1, 2
  typedef enum logic [1:0] {
    OFS_MOVING_AVERAGE,
    OFS_EXPONENTIAL_AVERAGE,
    OFS_MOVING_MEDIAN
  } ofs_kind_t;

  typedef enum logic [2:0] {
    OFS_NV_IDLE,
    OFS_NV_ENABLE,
    OFS_NV_TYPE,
    OFS_NV_CAPACITY,
    OFS_NV_PARAM
  } ofs_nv_step_t;
endpackage

// ===== design/ofs_decimator.sv
// sample rate decimator: averages each group of factor samples into one
`timescale 1ns/1ps
module ofs_decimator #(
  parameter int DW = 32,
  parameter int FW = 16
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic in_valid,
  input wire logic [DW-1:0] in_data,
  input wire logic [FW-1:0] factor,
  output logic out_valid,
  output logic [DW-1:0] out_data
);
  localparam int SW = DW + 7;

  typedef struct packed {
    logic [FW-1:0] cnt;
    logic [SW-1:0] sum;
    logic ov;
    logic [DW-1:0] od;
  } ofs_dec_state_t;

  ofs_dec_state_t s;
  ofs_dec_state_t next_s;
  logic [SW-1:0] total;

  always_comb begin
    next_s = s;
    next_s.ov = 1'b0;
    total = s.sum + SW'(in_data);
    if (in_valid) begin
      if (factor <= 16'h0001) begin
        // bypass: every sample goes on
        next_s.ov = 1'b1;
        next_s.od = in_data;
        next_s.cnt = '0;
        next_s.sum = '0;
      end else if (s.cnt >= factor - 16'h0001) begin
        // a shrunken factor also closes an overlong group here
        next_s.ov = 1'b1;
        next_s.od = DW'(total / SW'(factor));
        next_s.cnt = '0;
        next_s.sum = '0;
      end else begin
        next_s.cnt = s.cnt + 16'h0001;
        next_s.sum = total;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign out_valid = s.ov;
  assign out_data = s.od;
endmodule

// ===== design/ofs_out_buffer.sv
// output buffer of filter results, popped by register reads
`timescale 1ns/1ps
module ofs_out_buffer #(
  parameter int DW = 32,
  parameter int DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic push,
  input wire logic [DW-1:0] push_data,
  input wire logic pop,
  input wire logic [15:0] capacity,
  output logic [DW-1:0] head,
  output logic [15:0] level
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][DW-1:0] mem;
    logic [AW-1:0] rp;
    logic [AW-1:0] wp;
    logic [15:0] cnt;
  } ofs_buf_state_t;

  ofs_buf_state_t s;
  ofs_buf_state_t next_s;
  logic do_pop;
  logic do_push;

  always_comb begin
    next_s = s;
    do_pop = pop && (s.cnt != 16'h0000);
    // a full buffer keeps its oldest results and drops the new one
    do_push = push && ((s.cnt < capacity) || do_pop);
    if (do_pop) begin
      next_s.rp = (s.rp == AW'(DEPTH - 1)) ? '0 : s.rp + 1'b1;
    end
    if (do_push) begin
      next_s.mem[s.wp] = push_data;
      next_s.wp = (s.wp == AW'(DEPTH - 1)) ? '0 : s.wp + 1'b1;
    end
    next_s.cnt = s.cnt + 16'(do_push) - 16'(do_pop);
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign head = s.mem[s.rp];
  assign level = s.cnt;
endmodule

// ===== design/ofs_filter_stage.sv
// output filter stage of the digital flow path with its register bank
// How it works
// - write with nonzero low 16 bits to enable register enables the stage; zero there disables; enabled at reset
// - enable register reads back 1 or 0 only
// - analog output gets raw samples, untouched by any setting here
// - type code 0 moving average, 1 exponential average, 2 moving median
// - type register reads back the active filter code
// - settings writes other than decimation are volatile; store register copies them to nonvolatile storage
// - capacity write sets buffer size, clamped to the buffer maximum
// - capacity reads back the clamped value in effect
// - results wait in the buffer; each value read removes the oldest
// - parameter is window size, or one over alpha for exponential average
// - windows beyond the history size use the largest window possible
// - parameter zero: average on sample, or anti-noise median
// - parameter reads back the value in effect
// - 32-bit preset write loads all filter state with the given flow
// - preset register read pops and returns the next buffered result
// - decimator divides the rate by the clamped factor before filtering
// - decimation of 0 or 1 passes every sample
// - decimation write acts at once and is saved to storage by itself
// - decimation register reads back the setting in effect
`timescale 1ns/1ps
module ofs_filter_stage #(
  parameter int WIN_MAX = 16,
  parameter int BUF_DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [ofs_pkg::OFS_AW-1:0] addr,
  input wire logic [ofs_pkg::OFS_DW-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [ofs_pkg::OFS_DW-1:0] rd_data,
  input wire logic sample_valid,
  input wire logic [ofs_pkg::OFS_DW-1:0] sample_data,
  output logic analog_valid,
  output logic [ofs_pkg::OFS_DW-1:0] analog_data,
  output logic result_avail,
  output logic nv_write,
  output logic [ofs_pkg::OFS_AW-1:0] nv_addr,
  output logic [ofs_pkg::OFS_RW-1:0] nv_data
);
  localparam int DW = ofs_pkg::OFS_DW;
  localparam int SW = 64;
  localparam logic [15:0] WIN_LIM = 16'(WIN_MAX);
  localparam logic [15:0] BUF_LIM = 16'(BUF_DEPTH);

  typedef struct packed {
    logic enable;
    logic [1:0] kind;
    logic [15:0] capacity;
    logic [15:0] param;
    logic [15:0] decim;
    logic [WIN_MAX-1:0][DW-1:0] hist;
    logic [SW-1:0] sum_all;
    logic [DW-1:0] cnt_all;
    logic [DW-1:0] exponential_average;
    logic push;
    logic [DW-1:0] push_data;
    logic [DW-1:0] rd_data;
    logic an_valid;
    logic [DW-1:0] an_data;
    logic avail;
    ofs_pkg::ofs_nv_step_t nv_step;
    logic decim_pend;
    logic nv_write;
    logic [ofs_pkg::OFS_AW-1:0] nv_addr;
    logic [15:0] nv_data;
  } ofs_state_t;

  ofs_state_t s;
  ofs_state_t next_s;

  logic dec_valid;
  logic [DW-1:0] dec_data;
  logic pop;
  logic [DW-1:0] buf_head;
  logic [15:0] buf_level;
  logic [15:0] win;
  logic [15:0] ema_div;
  logic [WIN_MAX-1:0][DW-1:0] hist_new;
  logic [SW-1:0] wsum;
  logic [SW-1:0] sum_nx;
  logic [DW-1:0] cnt_nx;
  logic [DW-1:0] avg_out;
  logic [DW-1:0] med_out;
  logic [DW-1:0] ema_nx;
  logic [DW-1:0] filt;
  logic [15:0] wr_lo;

  // lower median of the n newest history entries, by rank counting
  function automatic logic [DW-1:0] ofs_median(
    input logic [WIN_MAX-1:0][DW-1:0] h,
    input int n
  );
    int less;
    int same;
    int k;
    logic [DW-1:0] res;
    res = h[0];
    k = (n - 1) / 2;
    for (int i = 0; i < WIN_MAX; i++) begin
      less = 0;
      same = 0;
      for (int j = 0; j < WIN_MAX; j++) begin
        if (i < n && j < n) begin
          if (h[j] < h[i]) begin
            less = less + 1;
          end else if (h[j] == h[i]) begin
            same = same + 1;
          end
        end
      end
      if (i < n && less <= k && less + same > k) begin
        res = h[i];
      end
    end
    return res;
  endfunction

  ofs_decimator #(
    .DW(DW),
    .FW(16)
  ) u_decimator (
    .core_clk(core_clk),
    .resetn(resetn),
    .in_valid(sample_valid),
    .in_data(sample_data),
    .factor(s.decim),
    .out_valid(dec_valid),
    .out_data(dec_data)
  );

  ofs_out_buffer #(
    .DW(DW),
    .DEPTH(BUF_DEPTH)
  ) u_out_buffer (
    .core_clk(core_clk),
    .resetn(resetn),
    .push(s.push),
    .push_data(s.push_data),
    .pop(pop),
    .capacity(s.capacity),
    .head(buf_head),
    .level(buf_level)
  );

  assign pop = rd_en && (addr == ofs_pkg::OFS_ADDR_PRESET);
  assign wr_lo = wr_data[15:0];

  // filter arithmetic on the history as it stands after the new sample
  always_comb begin
    hist_new = {s.hist[WIN_MAX-2:0], dec_data};
    win = (s.param > WIN_LIM) ? WIN_LIM : s.param;
    wsum = '0;
    for (int i = 0; i < WIN_MAX; i++) begin
      if (i < int'(win)) begin
        wsum = wsum + SW'(hist_new[i]);
      end
    end
    sum_nx = s.sum_all + SW'(dec_data);
    cnt_nx = (s.cnt_all == '1) ? s.cnt_all : s.cnt_all + 1'b1;
    if (win == 16'h0000) begin
      // average on sample: running mean since reset or preset
      avg_out = DW'(sum_nx / SW'(cnt_nx));
    end else begin
      avg_out = DW'(wsum / SW'(win));
    end
    if (win == 16'h0000) begin
      med_out = ofs_median(hist_new, ofs_pkg::OFS_NOISE_TAPS);
    end else begin
      med_out = ofs_median(hist_new, int'(win));
    end
    // a zero divisor has no meaning for alpha; treated as alpha of one
    ema_div = (s.param == 16'h0000) ? 16'h0001 : s.param;
    if (dec_data >= s.exponential_average) begin
      ema_nx = s.exponential_average + DW'((dec_data - s.exponential_average) / DW'(ema_div));
    end else begin
      ema_nx = s.exponential_average - DW'((s.exponential_average - dec_data) / DW'(ema_div));
    end
    case (s.kind)
      2'(ofs_pkg::OFS_MOVING_AVERAGE): filt = avg_out;
      2'(ofs_pkg::OFS_EXPONENTIAL_AVERAGE): filt = ema_nx;
      default: filt = med_out;
    endcase
  end

  always_comb begin
    next_s = s;
    next_s.push = 1'b0;
    next_s.an_valid = 1'b0;
    next_s.nv_write = 1'b0;
    next_s.rd_data = '0;
    next_s.avail = (buf_level != 16'h0000);

    // analog side sees the raw sample, ahead of any decimation
    if (sample_valid) begin
      next_s.an_valid = 1'b1;
      next_s.an_data = sample_data;
    end

    // all filters track every sample so a type change starts warm
    if (dec_valid) begin
      next_s.hist = hist_new;
      next_s.sum_all = sum_nx;
      next_s.cnt_all = cnt_nx;
      next_s.exponential_average = ema_nx;
      next_s.push = 1'b1;
      next_s.push_data = s.enable ? filt : dec_data;
    end

    // nonvolatile copies go out one word per cycle
    case (s.nv_step)
      ofs_pkg::OFS_NV_ENABLE: begin
        next_s.nv_write = 1'b1;
        next_s.nv_addr = ofs_pkg::OFS_ADDR_ENABLE;
        next_s.nv_data = {15'h0000, s.enable};
        next_s.nv_step = ofs_pkg::OFS_NV_TYPE;
      end
      ofs_pkg::OFS_NV_TYPE: begin
        next_s.nv_write = 1'b1;
        next_s.nv_addr = ofs_pkg::OFS_ADDR_TYPE;
        next_s.nv_data = {14'h0000, s.kind};
        next_s.nv_step = ofs_pkg::OFS_NV_CAPACITY;
      end
      ofs_pkg::OFS_NV_CAPACITY: begin
        next_s.nv_write = 1'b1;
        next_s.nv_addr = ofs_pkg::OFS_ADDR_CAPACITY;
        next_s.nv_data = s.capacity;
        next_s.nv_step = ofs_pkg::OFS_NV_PARAM;
      end
      ofs_pkg::OFS_NV_PARAM: begin
        next_s.nv_write = 1'b1;
        next_s.nv_addr = ofs_pkg::OFS_ADDR_PARAM;
        next_s.nv_data = s.param;
        next_s.nv_step = ofs_pkg::OFS_NV_IDLE;
      end
      default: begin
        if (s.decim_pend) begin
          next_s.nv_write = 1'b1;
          next_s.nv_addr = ofs_pkg::OFS_ADDR_DECIM;
          next_s.nv_data = s.decim;
          next_s.decim_pend = 1'b0;
        end
      end
    endcase

    // register writes come last so a new request wins over a clear
    if (wr_en) begin
      if (addr == ofs_pkg::OFS_ADDR_ENABLE) begin
        next_s.enable = (wr_lo != 16'h0000);
      end else if (addr == ofs_pkg::OFS_ADDR_TYPE) begin
        // codes without a filter behind them are ignored
        if (wr_lo < ofs_pkg::OFS_NUM_KINDS) begin
          next_s.kind = wr_lo[1:0];
        end
      end else if (addr == ofs_pkg::OFS_ADDR_CAPACITY) begin
        next_s.capacity = (wr_lo > BUF_LIM) ? BUF_LIM : wr_lo;
      end else if (addr == ofs_pkg::OFS_ADDR_PARAM) begin
        next_s.param = wr_lo;
      end else if (addr == ofs_pkg::OFS_ADDR_PRESET) begin
        for (int i = 0; i < WIN_MAX; i++) begin
          next_s.hist[i] = wr_data;
        end
        next_s.sum_all = SW'(wr_data);
        next_s.cnt_all = DW'(1);
        next_s.exponential_average = wr_data;
      end else if (addr == ofs_pkg::OFS_ADDR_DECIM) begin
        next_s.decim = (wr_lo > ofs_pkg::OFS_DECIM_MAX) ? ofs_pkg::OFS_DECIM_MAX : wr_lo;
        next_s.decim_pend = 1'b1;
      end else if (addr == ofs_pkg::OFS_ADDR_STORE) begin
        if (s.nv_step == ofs_pkg::OFS_NV_IDLE) begin
          next_s.nv_step = ofs_pkg::OFS_NV_ENABLE;
        end
      end
    end

    if (rd_en) begin
      if (addr == ofs_pkg::OFS_ADDR_ENABLE) begin
        next_s.rd_data = DW'(s.enable);
      end else if (addr == ofs_pkg::OFS_ADDR_TYPE) begin
        next_s.rd_data = DW'(s.kind);
      end else if (addr == ofs_pkg::OFS_ADDR_CAPACITY) begin
        next_s.rd_data = DW'(s.capacity);
      end else if (addr == ofs_pkg::OFS_ADDR_PARAM) begin
        // exponential divisor is not a window, so it is not limited
        if (s.kind == 2'(ofs_pkg::OFS_EXPONENTIAL_AVERAGE)) begin
          next_s.rd_data = DW'(s.param);
        end else begin
          next_s.rd_data = DW'(win);
        end
      end else if (addr == ofs_pkg::OFS_ADDR_PRESET) begin
        // an empty buffer reads as zero
        if (buf_level != 16'h0000) begin
          next_s.rd_data = buf_head;
        end
      end else if (addr == ofs_pkg::OFS_ADDR_DECIM) begin
        next_s.rd_data = DW'(s.decim);
      end else if (addr == ofs_pkg::OFS_ADDR_LEVEL) begin
        next_s.rd_data = DW'(buf_level);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      s <= '0;
      s.enable <= ofs_pkg::OFS_RST_ENABLE;
      s.kind <= ofs_pkg::OFS_RST_TYPE;
      s.capacity <= ofs_pkg::OFS_RST_CAPACITY;
      s.param <= ofs_pkg::OFS_RST_PARAM;
      s.decim <= ofs_pkg::OFS_RST_DECIM;
      s.nv_step <= ofs_pkg::OFS_NV_IDLE;
    end else begin
      s <= next_s;
    end
  end

  assign rd_data = s.rd_data;
  assign analog_valid = s.an_valid;
  assign analog_data = s.an_data;
  assign result_avail = s.avail;
  assign nv_write = s.nv_write;
  assign nv_addr = s.nv_addr;
  assign nv_data = s.nv_data;
endmodule

// ===== verif/ofs_filter_stage_chk.sv
// assertions on the output filter stage ports
`timescale 1ns/1ps
module ofs_filter_stage_chk #(
  parameter int BUF_DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [ofs_pkg::OFS_AW-1:0] addr,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [ofs_pkg::OFS_DW-1:0] rd_data,
  input wire logic sample_valid,
  input wire logic [ofs_pkg::OFS_DW-1:0] sample_data,
  input wire logic analog_valid,
  input wire logic [ofs_pkg::OFS_DW-1:0] analog_data,
  input wire logic nv_write,
  input wire logic [ofs_pkg::OFS_AW-1:0] nv_addr
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  logic [2:0] st_cnt;
  logic st_go;
  // a store write inside a running burst is ignored, so only idle ones start one
  assign st_go = wr_en && addr == ofs_pkg::OFS_ADDR_STORE && st_cnt == 3'h0;
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      st_cnt <= 3'h0;
    end else if (st_go) begin
      st_cnt <= 3'h4;
    end else if (st_cnt != 3'h0) begin
      st_cnt <= st_cnt - 3'h1;
    end
  end
  sequence s_burst;
    nv_write && nv_addr == ofs_pkg::OFS_ADDR_ENABLE ##1
    nv_write && nv_addr == ofs_pkg::OFS_ADDR_TYPE ##1
    nv_write && nv_addr == ofs_pkg::OFS_ADDR_CAPACITY ##1
    nv_write && nv_addr == ofs_pkg::OFS_ADDR_PARAM;
  endsequence
  property p_analog_copy;
    sample_valid |=> analog_valid && analog_data == $past(sample_data);
  endproperty
  property p_analog_idle;
    !sample_valid |=> !analog_valid;
  endproperty
  property p_en_bin;
    rd_en && addr == ofs_pkg::OFS_ADDR_ENABLE |=> rd_data[31:1] == 31'h0;
  endproperty
  property p_type_code;
    rd_en && addr == ofs_pkg::OFS_ADDR_TYPE |=> rd_data < 32'h3;
  endproperty
  property p_cap_clamp;
    rd_en && addr == ofs_pkg::OFS_ADDR_CAPACITY |=> rd_data <= BUF_DEPTH;
  endproperty
  property p_dec_clamp;
    rd_en && addr == ofs_pkg::OFS_ADDR_DECIM |=> rd_data <= 32'h40;
  endproperty
  property p_dec_save;
    wr_en && addr == ofs_pkg::OFS_ADDR_DECIM && st_cnt == 3'h0 |->
      ##2 nv_write && nv_addr == ofs_pkg::OFS_ADDR_DECIM;
  endproperty
  property p_store;
    st_go |-> ##2 s_burst;
  endproperty
  property p_nv_cause;
    $rose(nv_write) |-> $past(wr_en, 2) && ($past(addr, 2) == ofs_pkg::OFS_ADDR_STORE
      || $past(addr, 2) == ofs_pkg::OFS_ADDR_DECIM);
  endproperty
  a_analog_copy: assert property (p_analog_copy) else $error("analog copy wrong");
  a_analog_idle: assert property (p_analog_idle) else $error("stray analog");
  a_en_bin: assert property (p_en_bin) else $error("enable not 0 or 1");
  a_type_code: assert property (p_type_code) else $error("bad type code");
  a_cap_clamp: assert property (p_cap_clamp) else $error("capacity unclamped");
  a_dec_clamp: assert property (p_dec_clamp) else $error("decimation unclamped");
  a_dec_save: assert property (p_dec_save) else $error("decimation not saved");
  a_store: assert property (p_store) else $error("store burst wrong");
  a_nv_cause: assert property (p_nv_cause) else $error("unasked save");
endmodule
bind ofs_filter_stage ofs_filter_stage_chk #(.BUF_DEPTH(BUF_DEPTH)) ofs_filter_stage_chk_inst (
  .core_clk(core_clk),
  .resetn(resetn),
  .addr(addr),
  .wr_en(wr_en),
  .rd_en(rd_en),
  .rd_data(rd_data),
  .sample_valid(sample_valid),
  .sample_data(sample_data),
  .analog_valid(analog_valid),
  .analog_data(analog_data),
  .nv_write(nv_write),
  .nv_addr(nv_addr)
);

// ===== verif/ofs_flow_src.sv
// flow sample source model feeding one sample per call
`timescale 1ns/1ps
module ofs_flow_src (
  input wire logic core_clk,
  output logic sample_valid,
  output logic [ofs_pkg::OFS_DW-1:0] sample_data
);
  initial begin
    sample_valid = 1'b0;
    sample_data = 32'h0;
  end
  task automatic send(input logic [31:0] v);
    @(posedge core_clk);
    sample_valid <= 1'b1;
    sample_data <= v;
    @(posedge core_clk);
    sample_valid <= 1'b0;
    // idle data flips so a late capture cannot pass
    sample_data <= ~v;
  endtask
endmodule

// ===== verif/tb_top.sv
// self-checking bench for the output filter stage
`timescale 1ns/1ps
module tb_top;
  localparam logic [11:0] A_EN = ofs_pkg::OFS_ADDR_ENABLE;
  localparam logic [11:0] A_TY = ofs_pkg::OFS_ADDR_TYPE;
  localparam logic [11:0] A_CAP = ofs_pkg::OFS_ADDR_CAPACITY;
  localparam logic [11:0] A_PAR = ofs_pkg::OFS_ADDR_PARAM;
  localparam logic [11:0] A_PRE = ofs_pkg::OFS_ADDR_PRESET;
  localparam logic [11:0] A_DEC = ofs_pkg::OFS_ADDR_DECIM;
  localparam logic [11:0] A_LVL = ofs_pkg::OFS_ADDR_LEVEL;
  logic core_clk;
  logic resetn;
  logic [11:0] addr;
  logic [31:0] wr_data;
  logic wr_en;
  logic rd_en;
  logic [31:0] rd_data;
  logic sample_valid;
  logic [31:0] sample_data;
  logic result_avail;
  logic analog_valid;
  logic [31:0] analog_data;
  logic nv_write;
  logic [11:0] nv_addr;
  logic [15:0] nv_data;
  logic [31:0] got;
  int fails = 0;
  int n_compared = 0;
  int cycles = 0;

  ofs_filter_stage ofs_filter_stage_inst (
    .core_clk(core_clk),
    .resetn(resetn),
    .addr(addr),
    .wr_data(wr_data),
    .wr_en(wr_en),
    .rd_en(rd_en),
    .rd_data(rd_data),
    .sample_valid(sample_valid),
    .sample_data(sample_data),
    .analog_valid(analog_valid),
    .analog_data(analog_data),
    .result_avail(result_avail),
    .nv_write(nv_write),
    .nv_addr(nv_addr),
    .nv_data(nv_data)
  );
  ofs_flow_src src (
    .core_clk(core_clk),
    .sample_valid(sample_valid),
    .sample_data(sample_data)
  );

  task automatic check(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge core_clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge core_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    #1;
    check(rd_data, e);
  endtask
  task automatic settle;
    repeat (4) @(posedge core_clk);
  endtask
  // one nonvolatile word per cycle: pulse, offset and value packed together
  task automatic nv_chk(input logic [11:0] a, input logic [15:0] d);
    @(posedge core_clk);
    #1;
    check({nv_write, 3'h0, nv_addr, nv_data}, {1'b1, 3'h0, a, d});
  endtask
  // preset, then two samples, then pop both results
  task automatic filt(input logic [31:0] ty, input logic [31:0] par,
                      input logic [31:0] s1, input logic [31:0] e1,
                      input logic [31:0] s2, input logic [31:0] e2);
    wr(A_TY, ty);
    wr(A_PAR, par);
    wr(A_PRE, 32'ha);
    src.send(s1);
    src.send(s2);
    settle();
    rd(A_PRE, e1);
    rd(A_PRE, e2);
  endtask

  task automatic t_reset;
    rd(A_EN, 32'h1);
    rd(A_TY, 32'h1);
    rd(A_CAP, 32'ha);
    rd(A_PAR, 32'h2);
    rd(A_DEC, 32'h0);
    rd(A_PRE, 32'h0);
    rd(12'hf05, 32'h0);
    $display("test reset values done");
  endtask
  task automatic t_regs;
    wr(A_EN, 32'h5);
    rd(A_EN, 32'h1);
    wr(A_EN, 32'h0);
    rd(A_EN, 32'h0);
    for (int k = 0; k < 3; k++) begin
      wr(A_TY, 32'(k));
      rd(A_TY, 32'(k));
    end
    wr(A_TY, 32'h3);
    rd(A_TY, 32'h2);
    wr(A_CAP, 32'h64);
    rd(A_CAP, 32'h10);
    wr(A_TY, 32'h0);
    wr(A_PAR, 32'h28);
    rd(A_PAR, 32'h10);
    wr(A_TY, 32'h1);
    rd(A_PAR, 32'h28);
    $display("test register access done");
  endtask
  task automatic t_pass;
    src.send(32'h80000007);
    src.send(32'h9);
    src.send(32'hb);
    settle();
    check(analog_data, 32'hb);
    check({31'h0, result_avail}, 32'h1);
    rd(A_LVL, 32'h3);
    rd(A_PRE, 32'h80000007);
    rd(A_PRE, 32'h9);
    rd(A_PRE, 32'hb);
    rd(A_PRE, 32'h0);
    check({31'h0, result_avail}, 32'h0);
    wr(A_CAP, 32'h2);
    src.send(32'h1);
    src.send(32'h2);
    src.send(32'h3);
    settle();
    rd(A_LVL, 32'h2);
    rd(A_PRE, 32'h1);
    rd(A_PRE, 32'h2);
    rd(A_PRE, 32'h0);
    wr(A_CAP, 32'h10);
    $display("test disabled passthrough and capacity done");
  endtask
  task automatic t_decim;
    wr(A_DEC, 32'h2);
    nv_chk(A_DEC, 16'h2);
    src.send(32'ha);
    src.send(32'h14);
    src.send(32'h1e);
    src.send(32'h32);
    settle();
    rd(A_PRE, 32'hf);
    rd(A_PRE, 32'h28);
    rd(A_PRE, 32'h0);
    wr(A_DEC, 32'h64);
    rd(A_DEC, 32'h40);
    wr(A_DEC, 32'h1);
    rd(A_DEC, 32'h1);
    src.send(32'h5);
    settle();
    rd(A_PRE, 32'h5);
    wr(A_DEC, 32'h0);
    $display("test decimation done");
  endtask
  task automatic t_filters;
    wr(A_EN, 32'h1);
    filt(32'h1, 32'h4, 32'hc8, 32'h39, 32'hc8, 32'h5c);
    check(analog_data, 32'hc8);
    filt(32'h0, 32'h2, 32'h1e, 32'h14, 32'h32, 32'h28);
    filt(32'h2, 32'h3, 32'h28, 32'ha, 32'h28, 32'h28);
    filt(32'h0, 32'h0, 32'h1e, 32'h14, 32'h32, 32'h1e);
    filt(32'h2, 32'h0, 32'h28, 32'ha, 32'h28, 32'h28);
    wr(ofs_pkg::OFS_ADDR_STORE, 32'h0);
    nv_chk(A_EN, 16'h1);
    nv_chk(A_TY, 16'h2);
    nv_chk(A_CAP, 16'h10);
    nv_chk(A_PAR, 16'h0);
    repeat (4) @(posedge core_clk);
    $display("test filter kinds done");
  endtask

  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // the whole run needs well under a tenth of this
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails = fails + 1;
      conclude();
    end
  end
  initial begin
    resetn = 1'b0;
    addr = 12'h0;
    wr_data = 32'h0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    t_reset();
    t_regs();
    t_pass();
    t_decim();
    t_filters();
    conclude();
  end
endmodule
